// *** adt_params.svh ***
`ifndef ADT_PARAMS_SVH
`define ADT_PARAMS_SVH

// Model-specific register address of the deadline target
`define ADT_TARGET_ADDR 32'h0000_06E0
`define ADT_TARGET_RST 64'h0000_0000_0000_0000
// Timer vector entry fields
`define ADT_TVE_RST 32'h0001_0000
`define ADT_MODE_MSB 18
`define ADT_MODE_LSB 17
`define ADT_MASK_BIT 16
`define ADT_VEC_MSB 7
`define ADT_VEC_LSB 0
// Count registers
`define ADT_COUNT_RST 32'h0000_0000
// Feature-identification ECX bit position and its value
`define ADT_FEAT_BIT 24
`define ADT_FEAT_VAL 1'b1

`endif

// *** adt_pkg.sv ***
package adt_pkg;

  // Encoding follows declaration order: 00b, 01b, 10b, 11b
  typedef enum logic [1:0] {
    ADT_ONE_SHOT,
    ADT_PERIODIC,
    ADT_DEADLINE,
    ADT_RESERVED
  } adt_mode_e;

  typedef logic [63:0] adt_word_t;

endpackage

// *** adt_cmp.sv ***
`timescale 1ns/1ps

module adt_cmp (
  input wire logic armed,
  input wire adt_pkg::adt_word_t stamp,
  input wire adt_pkg::adt_word_t target,
  output logic reached
);

  // Both operands unsigned, so a target below the counter fires at once
  always_comb begin
    reached = armed && (stamp >= target);
  end

endmodule // adt_cmp

// *** adt_timer.sv ***
`timescale 1ns/1ps
`include "adt_params.svh"

// Notes on behaviour
// - deadline mode: initial count ignored, current reads 0
// - one deadline target register at 6E0H
// - non-zero target write arms timer
// - fire when counter reaches or passes target
// - compare as unsigned 64-bit values
// - firing disarms and zeroes target
// - writing zero disarms at any time
// - entering or leaving deadline mode disarms
// - reset leaves target zero, unarmed
// - outside deadline mode: target reads zero, writes dropped
// - mode field 10b selects deadline mode
// - feature bit 24 reports deadline support
// - accesses not serializing, kept in order
// - rewrite while armed moves deadline
// - modes exclusive; 11b reserved
module adt_timer (
  input wire logic clk,
  input wire logic arst_n,
  input wire adt_pkg::adt_word_t time_stamp_counter,
  input wire logic model_reg_write,
  input wire logic model_reg_read,
  input wire logic [31:0] model_reg_addr,
  input wire adt_pkg::adt_word_t model_reg_wdata,
  output adt_pkg::adt_word_t model_reg_rdata,
  output logic model_reg_rvalid,
  output logic model_reg_fault,
  input wire logic tve_write,
  input wire logic [31:0] tve_wdata,
  output logic [31:0] timer_vector_entry,
  input wire logic init_count_write,
  input wire logic [31:0] init_count_wdata,
  output logic [31:0] init_count,
  output logic [31:0] cur_count,
  output logic feat_deadline,
  output logic irq_req,
  output logic [7:0] irq_vector
);

  function automatic adt_pkg::adt_mode_e mode_of(input logic [31:0] v);
    return adt_pkg::adt_mode_e'(v[`ADT_MODE_MSB:`ADT_MODE_LSB]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic [31:0] tve_r, tve_nxt;
  adt_pkg::adt_word_t target_r, target_nxt;
  logic [31:0] icount_r, icount_nxt;
  logic [31:0] ccount_r, ccount_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] vec_r, vec_nxt;
  adt_pkg::adt_word_t rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic fault_r, fault_nxt;

  adt_pkg::adt_mode_e mode_cur;
  logic dl_mode;
  logic mode_chg;
  logic tgt_hit;
  logic tgt_wr;
  logic armed;
  logic reached;
  logic cnt_fire;

  assign mode_cur = mode_of(tve_r);
  assign dl_mode = (mode_cur == adt_pkg::ADT_DEADLINE);
  assign mode_chg = tve_write && (mode_of(tve_wdata) != mode_cur);
  assign tgt_hit = (model_reg_addr == `ADT_TARGET_ADDR);
  assign tgt_wr = model_reg_write && tgt_hit && dl_mode;
  // A zero target means unarmed, so the target doubles as the arm flag
  assign armed = dl_mode && (target_r != `ADT_TARGET_RST);
  assign cnt_fire = (mode_cur == adt_pkg::ADT_ONE_SHOT || mode_cur == adt_pkg::ADT_PERIODIC)
                    && (ccount_r == 32'h0000_0001);

  adt_cmp u_cmp (
    .armed(armed),
    .stamp(time_stamp_counter),
    .target(target_r),
    .reached(reached)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    tve_nxt = tve_write ? tve_wdata : tve_r;
    target_nxt = target_r;
    if (reached) begin
      target_nxt = `ADT_TARGET_RST;
    end
    // Write after a hit re-arms; the hit still raises its request
    if (tgt_wr) begin
      target_nxt = model_reg_wdata;
    end
    if (mode_chg) begin
      target_nxt = `ADT_TARGET_RST;
    end

    icount_nxt = icount_r;
    ccount_nxt = ccount_r;
    if (!dl_mode && mode_cur != adt_pkg::ADT_RESERVED) begin
      if (init_count_write) begin
        icount_nxt = init_count_wdata;
        ccount_nxt = init_count_wdata;
      end else if (ccount_r != `ADT_COUNT_RST) begin
        ccount_nxt = ccount_r - 32'h0000_0001;
        if (cnt_fire && mode_cur == adt_pkg::ADT_PERIODIC) begin
          ccount_nxt = icount_r;
        end
      end
    end
    if (mode_chg) begin
      ccount_nxt = `ADT_COUNT_RST;
    end

    irq_nxt = (reached || cnt_fire) && !tve_r[`ADT_MASK_BIT];
    vec_nxt = tve_r[`ADT_VEC_MSB:`ADT_VEC_LSB];

    // One access per cycle, answered in arrival order
    rvalid_nxt = model_reg_read;
    rdata_nxt = (tgt_hit && dl_mode) ? target_r : `ADT_TARGET_RST;
    fault_nxt = (model_reg_read || model_reg_write) && !tgt_hit;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tve_r <= `ADT_TVE_RST;
      target_r <= `ADT_TARGET_RST;
      icount_r <= `ADT_COUNT_RST;
      ccount_r <= `ADT_COUNT_RST;
      irq_r <= 1'b0;
      vec_r <= 8'h00;
      rdata_r <= `ADT_TARGET_RST;
      rvalid_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      tve_r <= tve_nxt;
      target_r <= target_nxt;
      icount_r <= icount_nxt;
      ccount_r <= ccount_nxt;
      irq_r <= irq_nxt;
      vec_r <= vec_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign model_reg_rdata = rdata_r;
  assign model_reg_rvalid = rvalid_r;
  assign model_reg_fault = fault_r;
  assign timer_vector_entry = tve_r;
  assign init_count = icount_r;
  assign cur_count = ccount_r;
  assign feat_deadline = `ADT_FEAT_VAL;
  assign irq_req = irq_r;
  assign irq_vector = vec_r;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_fire_clears: assert property ((reached && !tgt_wr && !mode_chg) |=> target_r == 64'h0)
    else $error("target not cleared after firing");
  // A write in the firing cycle may re-arm and fire again, so it is left out
  a_fire_request: assert property ((reached && !tve_r[`ADT_MASK_BIT] && !tgt_wr) |=>
    irq_req ##1 !irq_req)
    else $error("deadline reached but no single request");
  a_request_cause: assert property (irq_req |-> $past(reached) || $past(cnt_fire))
    else $error("request without cause");
  a_one_per_write: assert property ((reached && !tgt_wr && !mode_chg) |=> ##1 !irq_req)
    else $error("second request from one write");
  a_zero_disarms: assert property ((tgt_wr && model_reg_wdata == 64'h0 && !reached) |=>
    !armed ##1 !irq_req)
    else $error("zero write did not disarm");
  a_arm_write: assert property ((tgt_wr && !mode_chg) |=>
    target_r == $past(model_reg_wdata))
    else $error("target write not stored");
  a_arm_nonzero: assert property ((tgt_wr && !mode_chg && model_reg_wdata != 64'h0) |=>
    armed)
    else $error("non-zero target write left timer unarmed");
  // Relies on the stamp being free-running, never stepping backwards
  a_late_target: assert property ((tgt_wr && !mode_chg && model_reg_wdata != 64'h0 &&
    time_stamp_counter >= model_reg_wdata) |=> reached)
    else $error("already passed target did not fire");
  a_mode_disarm: assert property (mode_chg |=> target_r == 64'h0 && ccount_r == 32'h0)
    else $error("mode change left timer armed");
  a_cur_zero: assert property (dl_mode |-> cur_count == 32'h0)
    else $error("current count non-zero in deadline mode");
  a_icount_held: assert property ((init_count_write && dl_mode) |=> $stable(init_count))
    else $error("initial count written in deadline mode");
  a_off_read: assert property ((model_reg_read && tgt_hit && !dl_mode) |=>
    model_reg_rvalid && model_reg_rdata == 64'h0)
    else $error("target readable outside deadline mode");
  a_read_answer: assert property ((model_reg_read && tgt_hit && dl_mode) |=>
    model_reg_rvalid && model_reg_rdata == $past(target_r))
    else $error("target read returned a wrong value");
  a_off_write: assert property ((model_reg_write && !dl_mode && target_r == 64'h0) |=>
    target_r == 64'h0)
    else $error("target written outside deadline mode");
  a_fault_pulse: assert property (((model_reg_read || model_reg_write) && !tgt_hit) |=>
    model_reg_fault)
    else $error("unmapped access not flagged");
  a_no_fault: assert property (((model_reg_read || model_reg_write) && tgt_hit) |=>
    !model_reg_fault)
    else $error("mapped access flagged as unmapped");
  // Requests carry the vector that the entry held in the compare cycle
  a_req_vector: assert property (irq_req |->
    irq_vector == $past(tve_r[`ADT_VEC_MSB:`ADT_VEC_LSB]))
    else $error("request vector differs from entry");
  // A masked hit still disarms but must stay silent
  a_mask_quiet: assert property ((reached && tve_r[`ADT_MASK_BIT]) |=> !irq_req)
    else $error("masked deadline raised a request");

  c_arm_fire: cover property (tgt_wr ##[1:20] irq_req);
  c_rearm: cover property (armed && tgt_wr && model_reg_wdata != 64'h0);
  c_disarm: cover property (armed && tgt_wr && model_reg_wdata == 64'h0);
  c_periodic: cover property (cnt_fire && mode_cur == adt_pkg::ADT_PERIODIC);
  c_masked_fire: cover property (reached && tve_r[`ADT_MASK_BIT]);

endmodule // adt_timer

// *** adt_timer_bench.sv ***
`timescale 1ns/1ps
`include "adt_params.svh"
module adt_timer_bench;
  typedef struct packed {
    logic [1:0] m;
    adt_pkg::adt_word_t d;
    adt_pkg::adt_word_t e;
  } adt_row_s;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr = 1'b0, rd = 1'b0, tw = 1'b0, iw = 1'b0;
  logic [31:0] addr = '0, tdata = '0, idata = 32'h0000_0055;
  adt_pkg::adt_word_t stamp = '0, wdata = '0, rdata;
  logic rvalid, fault, feat, irq;
  logic [31:0] tve, icnt, ccnt;
  logic [7:0] vec;
  int error_cnt = 0, compares = 0, cyc = 0, n;
  // Mode changes between rows also exercise the disarm path
  adt_row_s rows [5] = '{'{2'h0, 64'hFFFF_0000_0000_0001, 64'h0},
    '{2'h1, 64'hFFFF_0000_0000_0001, 64'h0},
    '{2'h2, 64'hFFFF_0000_0000_0001, 64'hFFFF_0000_0000_0001},
    '{2'h3, 64'hFFFF_0000_0000_0001, 64'h0},
    '{2'h2, 64'h8000_0000_0000_0000, 64'h8000_0000_0000_0000}};
  adt_timer u_dut (.clk(clk), .arst_n(arst_n), .time_stamp_counter(stamp),
    .model_reg_write(wr), .model_reg_read(rd), .model_reg_addr(addr), .model_reg_wdata(wdata),
    .model_reg_rdata(rdata), .model_reg_rvalid(rvalid), .model_reg_fault(fault),
    .tve_write(tw), .tve_wdata(tdata), .timer_vector_entry(tve), .init_count_write(iw),
    .init_count_wdata(idata), .init_count(icnt), .cur_count(ccnt), .feat_deadline(feat),
    .irq_req(irq), .irq_vector(vec));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input adt_pkg::adt_word_t e, input adt_pkg::adt_word_t g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tve_set(input logic [1:0] m, input logic mk);
    @(negedge clk);
    tw = 1'b1;
    tdata = {13'h0000, m, mk, 16'h005A};
    @(negedge clk);
    tw = 1'b0;
  endtask
  task automatic wr_reg(input adt_pkg::adt_word_t d);
    @(negedge clk);
    wr = 1'b1;
    addr = `ADT_TARGET_ADDR;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [31:0] a, input adt_pkg::adt_word_t e, input logic f);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk("rvalid", 64'h1, {63'h0, rvalid});
    chk("rdata", e, rdata);
    chk("fault", {63'h0, f}, {63'h0, fault});
  endtask
  // Counting over a window catches both a missing and a repeated request
  task automatic watch(input int exp);
    n = 0;
    repeat (8) begin
      @(negedge clk);
      if (irq === 1'b1) begin
        n++;
        chk("irq_vector", 64'h5A, {56'h0, vec});
      end
    end
    chk("irq_count", 64'(exp), 64'(n));
  endtask
  task automatic end_sim();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    chk("entry", 64'h0001_0000, {32'h0, tve});
    chk("feat", 64'h1, {63'h0, feat});
    rd_reg(`ADT_TARGET_ADDR, 64'h0, 1'b0);
    tve_set(2'h2, 1'b0);
    @(negedge clk) iw = 1'b1;
    @(negedge clk) iw = 1'b0;
    chk("init_count", 64'h0, {32'h0, icnt});
    chk("cur_count", 64'h0, {32'h0, ccnt});
    foreach (rows[i]) begin
      tve_set(rows[i].m, 1'b0);
      wr_reg(rows[i].d);
      rd_reg(`ADT_TARGET_ADDR, rows[i].e, 1'b0);
    end
    tve_set(2'h1, 1'b0);
    tve_set(2'h2, 1'b0);
    rd_reg(`ADT_TARGET_ADDR, 64'h0, 1'b0);
    stamp = 64'h64;
    wr_reg(64'h69);
    watch(0);
    stamp = 64'h69;
    watch(1);
    rd_reg(`ADT_TARGET_ADDR, 64'h0, 1'b0);
    wr_reg(64'h200);
    wr_reg(64'h60);
    watch(1);
    wr_reg(64'h70);
    wr_reg(64'h0);
    stamp = 64'h80;
    watch(0);
    stamp = 64'h8000_0000_0000_0000;
    wr_reg(64'h7FFF_FFFF_FFFF_FFFF);
    watch(1);
    tve_set(2'h2, 1'b1);
    wr_reg(64'h10);
    watch(0);
    rd_reg(`ADT_TARGET_ADDR, 64'h0, 1'b0);
    rd_reg(32'h0000_06E1, 64'h0, 1'b1);
    // Count registers work outside deadline mode and the current count is zeroed on entry
    tve_set(2'h0, 1'b1);
    @(negedge clk) iw = 1'b1;
    @(negedge clk) iw = 1'b0;
    chk("init_count", 64'h55, {32'h0, icnt});
    tve_set(2'h2, 1'b1);
    chk("cur_count", 64'h0, {32'h0, ccnt});
    // Far target first, read back once and checked against the written value
    wr_reg(64'hFFFF_FFFF_FFFF_FFFF);
    rd_reg(`ADT_TARGET_ADDR, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
    // Reset in mid-run must drop the armed target and restore the entry
    @(negedge clk) arst_n = 1'b0;
    @(negedge clk) arst_n = 1'b1;
    chk("entry", 64'h0001_0000, {32'h0, tve});
    tve_set(2'h2, 1'b0);
    rd_reg(`ADT_TARGET_ADDR, 64'h0, 1'b0);
    watch(0);
    end_sim();
  end
endmodule // adt_timer_bench
